/* design/di_decoder_params.svh */
// Constants for the digital input terminal function decoder.
// Included by the decoder package and modules; no logic here.
`ifndef DI_DECODER_PARAMS_SVH
`define DI_DECODER_PARAMS_SVH

// Terminal function codes
`define FN_HOLD_FREQ     6'h15
`define FN_PID_PAUSE     6'h16
`define FN_SEQ_RESET     6'h17
`define FN_TORQUE_INH    6'h1D
`define FN_DC_BRAKE      6'h20
`define FN_EXT_FAULT_NC  6'h21
`define FN_FREQ_LOCK     6'h22
`define FN_PID_INVERT    6'h23
`define FN_PANEL_STOP    6'h24
`define FN_TO_COMM       6'h25
`define FN_INTEG_PAUSE   6'h26
`define FN_PRESET_X      6'h27
`define FN_PRESET_Y      6'h28
`define FN_PID_BANK      6'h2B
`define FN_USER_FAULT1   6'h2C
`define FN_USER_FAULT2   6'h2D
`define FN_MODE_TOGGLE   6'h2E
`define FN_EMERG_STOP    6'h2F
`define FN_DECEL4_STOP   6'h30
`define FN_DECEL_DC      6'h31
`define FN_CLR_RUNTIME   6'h32
`define FN_TRACK_STOP    6'h35

// Command source encodings
`define SRC_PANEL        2'h0
`define SRC_TERMINAL     2'h1
`define SRC_COMM         2'h2

// Bank selector value meaning switch by terminal
`define BANK_BY_TERMINAL 2'h1

// Field widths
`define CODE_W           6
`define NUM_TERMINALS    6

`endif

/* design/di_decoder_pkg.sv */
// Types shared by the decoder modules.
// Assumes the constants header is on the include path.
`include "di_decoder_params.svh"

package di_decoder_pkg;

    // Control requests toward the drive core
    typedef struct packed {
        logic hold_freq;
        logic pid_pause;
        logic seq_reset;
        logic torque_inh;
        logic dc_brake;
        logic ext_fault;
        logic freq_lock;
        logic pid_invert;
        logic panel_stop;
        logic integ_pause;
        logic preset_x;
        logic preset_y;
        logic pid_bank;
        logic user_fault1;
        logic user_fault2;
        logic mode_toggle;
        logic emerg_stop;
        logic decel4_stop;
        logic decel_dc;
        logic track_stop;
    } req_t;

endpackage

/* design/term_sync_if.sv */
// Interface carrying synchronised terminal levels and edges.
// Joins the input conditioner to the decoder top.
`timescale 1ns/10ps

interface term_sync_if #(
    parameter int N = 6
);
    logic [N-1:0] level;   // Stable terminal level
    logic [N-1:0] rise;    // One-cycle pulse on off-to-on change

    modport src (output level, output rise);
    modport dst (input level, input rise);
endinterface

/* design/term_sync.sv */
// Terminal input conditioner: three-stage synchroniser per terminal.
// Assumes asynchronous contact levels; one clock domain.
`timescale 1ns/10ps

module term_sync #(
    parameter int N = 6
) (
    input  wire logic         clk_i,   // System clock
    input  wire logic         nrst_i,  // Async reset, active low
    input  wire logic [N-1:0] pin_i,   // Raw terminal levels
    term_sync_if.src          sync     // Conditioned levels and edges
);

    logic [N-1:0] s1;
    logic [N-1:0] s2;
    logic [N-1:0] s3;
    logic [N-1:0] level;

    // --------------------------------------------------------------
    // Synchroniser chain
    // --------------------------------------------------------------
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
        end else begin
            s1 <= pin_i;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // Accept a change only once the second and third stages agree
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            level <= '0;
        end else begin
            for (int i = 0; i < N; i++) begin
                if (s2[i] == s3[i]) begin
                    level[i] <= s3[i];
                end
            end
        end
    end

    // Edge pulse comes one cycle before the accepted level rises
    always_comb begin
        sync.rise = (s2 & s3) & ~level;
    end
    assign sync.level = level;

endmodule

/* design/di_terminal_function_decoder.sv */
// Digital input terminal function decoder for a drive.
// Assumes contacts on pins, settings as static ports, one clock.
//
// Notes on behaviour
// - Code zero on a terminal gives no request.
// - Code 21 active holds output frequency; only stop still acts.
// - Code 22 active suspends PID frequency adjustment, keeps frequency.
// - Code 23 requests multi-step sequence reset on restart after pause.
// - Code 29 active inhibits torque control, forces speed mode.
// - Code 32 turning active enters DC braking at once.
// - Code 33 fault input asserted raises external fault and stops.
// - Code 34 active ignores all frequency modification requests.
// - Code 35 active inverts the configured PID direction.
// - Code 36 stops like panel stop key when panel is source.
// - Code 37 rising under terminal source switches to communication.
// - Code 38 active freezes PID integral; P and D keep working.
// - Codes 39 and 40 substitute preset frequency for X and Y.
// - Code 43 picks PID bank two when active, bank selector one.
// - Codes 44 and 45 raise user faults one and two.
// - Code 46 active selects opposite of configured control mode.
// - Code 47 requests minimum-time stop at current upper limit.
// - Code 48 decelerates to stop with time four, any source.
// - Code 49 decelerates to brake start frequency then DC brakes.
// - Code 50 clears running time when running-time settings allow.
// - Code 53 stops maximum power tracking, ordinary speed mode.
`timescale 1ns/10ps
`include "di_decoder_params.svh"

module di_terminal_function_decoder
    import di_decoder_pkg::*;
#(
    parameter int N = `NUM_TERMINALS
) (
    input  wire logic                   clk_i,              // Clock
    input  wire logic                   nrst_i,             // Reset, low
    input  wire logic [N-1:0]           term_i,             // Terminals
    input  wire logic [N*`CODE_W-1:0]   func_code_i,        // Codes
    input  wire logic [1:0]             cmd_source_i,       // Source now
    input  wire logic                   pid_direction_setting_i, // Dir
    input  wire logic [1:0]             pid_bank_switch_selector_i, // Sel
    input  wire logic                   control_mode_setting_i, // 1=torque
    input  wire logic                   running_time_enable_setting_i,
    input  wire logic                   running_time_counter_setting_i,
    output logic                        hold_freq_o,        // Hold freq
    output logic                        pid_pause_o,        // PID paused
    output logic                        seq_reset_o,        // Seq reset
    output logic                        speed_mode_force_o, // Speed only
    output logic                        dc_brake_o,         // DC brake now
    output logic                        external_fault_report_o, // Fault
    output logic                        stop_o,             // Stop request
    output logic                        freq_lock_o,        // No freq edit
    output logic                        pid_dir_o,          // PID dir
    output logic                        panel_stop_o,       // Panel stop
    output logic                        switch_to_comm_o,   // Pulse
    output logic                        integ_freeze_o,     // I frozen
    output logic                        preset_x_o,         // X preset
    output logic                        preset_y_o,         // Y preset
    output logic                        pid_bank_two_o,     // Bank two
    output logic                        user_fault_one_report_o, // UF1
    output logic                        user_fault_two_report_o, // UF2
    output logic                        torque_mode_o,      // Mode used
    output logic                        emerg_stop_o,       // Fast stop
    output logic                        decel4_stop_o,      // Time 4 stop
    output logic                        decel_dc_brake_o,   // Decel+brake
    output logic                        clr_runtime_o,      // Clear pulse
    output logic                        track_stop_o        // Tracking off
);

    // ----------------------------------------------------------------
    // Terminal conditioning
    // ----------------------------------------------------------------
    term_sync_if #(.N(N)) sync_bus ();

    term_sync #(.N(N)) u_sync (
        .clk_i  (clk_i),
        .nrst_i (nrst_i),
        .pin_i  (term_i),
        .sync   (sync_bus.src)
    );

    // ----------------------------------------------------------------
    // Decoding
    // ----------------------------------------------------------------

    // OR together every terminal whose code matches and whose flag is set
    function automatic logic any_match(
        input logic [N*`CODE_W-1:0] codes,
        input logic [N-1:0]         flags,
        input logic [`CODE_W-1:0]   code
    );
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < N; i++) begin
            if (flags[i] && codes[i*`CODE_W +: `CODE_W] == code) begin
                hit = 1'b1;
            end
        end
        return hit;
    endfunction

    req_t lvl;
    logic rise_dc;
    logic rise_comm;
    logic rise_clr;

    // Level requests: codes 0 and undefined codes never match
    always_comb begin
        lvl = '0;
        lvl.hold_freq   = any_match(func_code_i, sync_bus.level,
                                    `FN_HOLD_FREQ);
        lvl.pid_pause   = any_match(func_code_i, sync_bus.level,
                                    `FN_PID_PAUSE);
        lvl.seq_reset   = any_match(func_code_i, sync_bus.level,
                                    `FN_SEQ_RESET);
        lvl.torque_inh  = any_match(func_code_i, sync_bus.level,
                                    `FN_TORQUE_INH);
        lvl.dc_brake    = any_match(func_code_i, sync_bus.level,
                                    `FN_DC_BRAKE);
        lvl.ext_fault   = any_match(func_code_i, sync_bus.level,
                                    `FN_EXT_FAULT_NC);
        lvl.freq_lock   = any_match(func_code_i, sync_bus.level,
                                    `FN_FREQ_LOCK);
        lvl.pid_invert  = any_match(func_code_i, sync_bus.level,
                                    `FN_PID_INVERT);
        lvl.panel_stop  = any_match(func_code_i, sync_bus.level,
                                    `FN_PANEL_STOP);
        lvl.integ_pause = any_match(func_code_i, sync_bus.level,
                                    `FN_INTEG_PAUSE);
        lvl.preset_x    = any_match(func_code_i, sync_bus.level,
                                    `FN_PRESET_X);
        lvl.preset_y    = any_match(func_code_i, sync_bus.level,
                                    `FN_PRESET_Y);
        lvl.pid_bank    = any_match(func_code_i, sync_bus.level,
                                    `FN_PID_BANK);
        lvl.user_fault1 = any_match(func_code_i, sync_bus.level,
                                    `FN_USER_FAULT1);
        lvl.user_fault2 = any_match(func_code_i, sync_bus.level,
                                    `FN_USER_FAULT2);
        lvl.mode_toggle = any_match(func_code_i, sync_bus.level,
                                    `FN_MODE_TOGGLE);
        lvl.emerg_stop  = any_match(func_code_i, sync_bus.level,
                                    `FN_EMERG_STOP);
        lvl.decel4_stop = any_match(func_code_i, sync_bus.level,
                                    `FN_DECEL4_STOP);
        lvl.decel_dc    = any_match(func_code_i, sync_bus.level,
                                    `FN_DECEL_DC);
        lvl.track_stop  = any_match(func_code_i, sync_bus.level,
                                    `FN_TRACK_STOP);
    end

    // Edge-triggered requests
    always_comb begin
        rise_dc   = any_match(func_code_i, sync_bus.rise, `FN_DC_BRAKE);
        rise_comm = any_match(func_code_i, sync_bus.rise, `FN_TO_COMM);
        rise_clr  = any_match(func_code_i, sync_bus.rise, `FN_CLR_RUNTIME);
    end

    // ----------------------------------------------------------------
    // Holding and PID requests
    // ----------------------------------------------------------------

    // Frequency hold, PID pause and frequency lock
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            hold_freq_o    <= 1'b0;
            pid_pause_o    <= 1'b0;
            freq_lock_o    <= 1'b0;
            integ_freeze_o <= 1'b0;
            pid_dir_o      <= 1'b0;
            pid_bank_two_o <= 1'b0;
        end else begin
            hold_freq_o    <= lvl.hold_freq;
            pid_pause_o    <= lvl.pid_pause;
            freq_lock_o    <= lvl.freq_lock;
            integ_freeze_o <= lvl.integ_pause;
            pid_dir_o      <= pid_direction_setting_i
                              ^ lvl.pid_invert;
            pid_bank_two_o <= (pid_bank_switch_selector_i
                               == `BANK_BY_TERMINAL)
                              && lvl.pid_bank;
        end
    end

    // ----------------------------------------------------------------
    // Mode and source requests
    // ----------------------------------------------------------------

    // Control mode, presets, sequence reset and tracking stop
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            speed_mode_force_o <= 1'b0;
            torque_mode_o      <= 1'b0;
            preset_x_o         <= 1'b0;
            preset_y_o         <= 1'b0;
            seq_reset_o        <= 1'b0;
            track_stop_o       <= 1'b0;
        end else begin
            speed_mode_force_o <= lvl.torque_inh
                                  | lvl.track_stop;
            // Inhibit and tracking stop win over the mode toggle
            torque_mode_o      <= (control_mode_setting_i
                                   ^ lvl.mode_toggle)
                                  & ~lvl.torque_inh
                                  & ~lvl.track_stop;
            preset_x_o         <= lvl.preset_x;
            preset_y_o         <= lvl.preset_y;
            seq_reset_o        <= lvl.seq_reset;
            track_stop_o       <= lvl.track_stop;
        end
    end

    // Switch to communication on a rising terminal under terminal source
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            switch_to_comm_o <= 1'b0;
        end else begin
            switch_to_comm_o <= rise_comm
                && (cmd_source_i == `SRC_TERMINAL);
        end
    end

    // Runtime clear pulse, gated by both running-time settings
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            clr_runtime_o <= 1'b0;
        end else begin
            clr_runtime_o <= rise_clr
                && running_time_enable_setting_i
                && running_time_counter_setting_i;
        end
    end

    // ----------------------------------------------------------------
    // Stop, brake and fault requests
    // ----------------------------------------------------------------

    // DC braking latches on the rising edge and holds while active
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            dc_brake_o <= 1'b0;
        end else begin
            dc_brake_o <= rise_dc | lvl.dc_brake;
        end
    end

    // Faults and stop variants
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            external_fault_report_o <= 1'b0;
            user_fault_one_report_o <= 1'b0;
            user_fault_two_report_o <= 1'b0;
            panel_stop_o            <= 1'b0;
            emerg_stop_o            <= 1'b0;
            decel4_stop_o           <= 1'b0;
            decel_dc_brake_o        <= 1'b0;
        end else begin
            external_fault_report_o <= lvl.ext_fault;
            user_fault_one_report_o <= lvl.user_fault1;
            user_fault_two_report_o <= lvl.user_fault2;
            panel_stop_o            <= lvl.panel_stop
                && (cmd_source_i == `SRC_PANEL);
            emerg_stop_o            <= lvl.emerg_stop;
            decel4_stop_o           <= lvl.decel4_stop;
            decel_dc_brake_o        <= lvl.decel_dc;
        end
    end

    // Combined stop request; a stop still acts during frequency hold
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            stop_o <= 1'b0;
        end else begin
            stop_o <= lvl.ext_fault
                | (lvl.panel_stop
                   && (cmd_source_i == `SRC_PANEL))
                | lvl.emerg_stop
                | lvl.decel4_stop
                | lvl.decel_dc;
        end
    end

endmodule

/* test/di_decoder_checker.sv */
// Concurrent checks on the terminal function decoder's ports.
// Assumes binding to the decoder top; one clock, async low reset.
`timescale 1ns/10ps
`include "di_decoder_params.svh"

module di_decoder_checker #(
    parameter int N = 6
) (
    input wire logic                 clk_i,       // Clock
    input wire logic                 nrst_i,      // Reset, low
    input wire logic [N-1:0]         term_i,      // Terminals
    input wire logic [N*`CODE_W-1:0] func_code_i, // Codes
    input wire logic [1:0]           cmd_source_i, // Source
    input wire logic                 pid_direction_setting_i, // Dir
    input wire logic [1:0]           pid_bank_switch_selector_i, // Sel
    input wire logic                 running_time_enable_setting_i,
    input wire logic                 running_time_counter_setting_i,
    input wire logic                 hold_freq_o,      // Hold
    input wire logic                 dc_brake_o,       // Brake
    input wire logic                 external_fault_report_o, // Fault
    input wire logic                 stop_o,           // Stop
    input wire logic                 pid_dir_o,        // PID dir
    input wire logic                 panel_stop_o,     // Panel stop
    input wire logic                 switch_to_comm_o, // Pulse
    input wire logic                 pid_bank_two_o,   // Bank two
    input wire logic                 emerg_stop_o,     // Fast stop
    input wire logic                 clr_runtime_o,    // Pulse
    input wire logic                 speed_mode_force_o, // Speed
    input wire logic                 torque_mode_o     // Mode
);
    // ----------------
    // Helpers
    // ----------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    // True while any closed terminal carries code k
    function automatic logic hit(input logic [`CODE_W-1:0] k);
        logic h;
        h = 1'b0;
        for (int i = 0; i < N; i++) begin
            if (term_i[i] && func_code_i[i*`CODE_W +: `CODE_W] == k)
                h = 1'b1;
        end
        return h;
    endfunction

    // ----------------
    // Assertions
    // ----------------
    a_hold_follows: assert property (
        hit(`FN_HOLD_FREQ) [*6] |-> hold_freq_o)
        else $error("hold request missing");
    a_dc_brake_on: assert property (
        hit(`FN_DC_BRAKE) [*6] |-> dc_brake_o)
        else $error("dc brake missing");
    a_ext_fault_stop: assert property (
        hit(`FN_EXT_FAULT_NC) [*6] |-> external_fault_report_o && stop_o)
        else $error("external fault or stop missing");
    a_emerg_stop_on: assert property (
        hit(`FN_EMERG_STOP) [*6] |-> emerg_stop_o && stop_o)
        else $error("emergency stop missing");
    a_pid_dir_plain: assert property (
        (!hit(`FN_PID_INVERT) && $stable(pid_direction_setting_i)) [*6]
        |-> pid_dir_o == pid_direction_setting_i)
        else $error("pid direction not the setting");
    a_panel_stop_src: assert property (
        panel_stop_o |-> $past(cmd_source_i) == `SRC_PANEL)
        else $error("panel stop outside panel source");
    a_comm_pulse_once: assert property (
        switch_to_comm_o |-> $past(cmd_source_i) == `SRC_TERMINAL
        ##1 !switch_to_comm_o)
        else $error("comm switch pulse wrong");
    a_bank_by_term: assert property (
        pid_bank_two_o |-> $past(pid_bank_switch_selector_i)
        == `BANK_BY_TERMINAL)
        else $error("bank two without terminal selector");
    a_clear_pulse_once: assert property (
        clr_runtime_o |-> $past(running_time_enable_setting_i)
        && $past(running_time_counter_setting_i) ##1 !clr_runtime_o)
        else $error("runtime clear pulse wrong");
    a_speed_no_torque: assert property (
        speed_mode_force_o |-> !torque_mode_o)
        else $error("torque mode while speed forced");
endmodule

/* test/term_contacts.sv */
// External switch contacts wired to the drive's input terminals.
// Assumes the bench calls set_level; contacts move after an edge.
`timescale 1ns/10ps

module term_contacts #(
    parameter int N = 6
) (
    input  wire logic    clk_i,  // Bench clock for timing
    output logic [N-1:0] term_o  // Contact levels, high = closed
);
    // ----------------
    // Contacts
    // ----------------
    // All contacts open at power-up
    initial term_o = '0;

    // Close or open one contact just after a rising edge
    task automatic set_level(input int idx, input logic lvl);
        @(posedge clk_i);
        #1 term_o[idx] = lvl;
    endtask
endmodule

/* test/di_terminal_function_decoder_test.sv */
// Self-checking bench for the terminal function decoder.
// Assumes the contact model drives terminals; one 250 MHz clock.
`timescale 1ns/10ps
`include "di_decoder_params.svh"

module di_terminal_function_decoder_test;
    localparam int N = `NUM_TERMINALS;
    localparam logic [2:0] T_DIR  = 3'h2;
    localparam logic [2:0] T_MODE = 3'h6;
    localparam logic [2:0] T_RTE  = 3'h5;
    localparam logic [2:0] T_RTC  = 3'h3;
    logic [1:0]           t_src [3] = '{`SRC_PANEL, `SRC_TERMINAL, `SRC_COMM};
    logic [1:0]           t_sel [3] = '{2'h1, 2'h0, 2'h2};
    logic                 clk_i;
    logic                 nrst_i;
    logic [N-1:0]         term_i;
    logic [N*`CODE_W-1:0] func_code_i;
    logic [1:0]           src;
    logic                 dir;
    logic [1:0]           sel;
    logic                 mode;
    logic                 rte;
    logic                 rtc;
    wire  [19:0]          lv;
    logic                 comm_p;
    logic                 clr_p;
    logic                 stop_s;
    int                   fails;
    int                   n_compared;

    // ----------------
    // Clock, contacts and decoder
    // ----------------
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    term_contacts #(.N(N)) contacts (.clk_i(clk_i), .term_o(term_i));

    di_terminal_function_decoder #(.N(N)) uut (
        .clk_i(clk_i), .nrst_i(nrst_i), .term_i(term_i),
        .func_code_i(func_code_i), .cmd_source_i(src),
        .pid_direction_setting_i(dir), .pid_bank_switch_selector_i(sel),
        .control_mode_setting_i(mode),
        .running_time_enable_setting_i(rte),
        .running_time_counter_setting_i(rtc),
        .hold_freq_o(lv[19]), .pid_pause_o(lv[18]), .seq_reset_o(lv[17]),
        .speed_mode_force_o(lv[16]), .dc_brake_o(lv[15]),
        .external_fault_report_o(lv[14]), .stop_o(stop_s),
        .freq_lock_o(lv[13]), .pid_dir_o(lv[12]), .panel_stop_o(lv[11]),
        .switch_to_comm_o(comm_p), .integ_freeze_o(lv[10]),
        .preset_x_o(lv[9]), .preset_y_o(lv[8]), .pid_bank_two_o(lv[7]),
        .user_fault_one_report_o(lv[6]), .user_fault_two_report_o(lv[5]),
        .torque_mode_o(lv[4]), .emerg_stop_o(lv[3]), .decel4_stop_o(lv[2]),
        .decel_dc_brake_o(lv[1]), .clr_runtime_o(clr_p),
        .track_stop_o(lv[0])
    );

    // ----------------
    // Expectations and tasks
    // ----------------
    // Level outputs expected while one terminal with code c is closed
    function automatic logic [19:0] expect_lv(input int c);
        logic sp;
        sp = (c == 29) || (c == 53);
        return {c == 21, c == 22, c == 23, sp, c == 32, c == 33, c == 34,
                dir ^ (c == 35), (c == 36) && (src == `SRC_PANEL),
                c == 38, c == 39, c == 40,
                (c == 43) && (sel == `BANK_BY_TERMINAL), c == 44, c == 45,
                (mode ^ (c == 46)) && !sp, c == 47, c == 48, c == 49,
                c == 53};
    endfunction

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("FAIL %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    // Close then open one terminal carrying code c, counting pulses
    task automatic run_code(input int c);
        int          t;
        logic [31:0] nc;
        logic [31:0] nr;
        logic [19:0] e;
        t = c % N;
        nc = 0;
        nr = 0;
        e = expect_lv(c);
        func_code_i = '0;
        func_code_i[t*`CODE_W +: `CODE_W] = c[5:0];
        for (int ph = 1; ph >= 0; ph--) begin
            contacts.set_level(t, ph[0]);
            repeat (8) begin
                @(posedge clk_i);
                #1 nc += comm_p;
                nr += clr_p;
            end
            if (ph == 1) begin
                check("levels", lv, e);
                if (c == 33 || c == 47 || c == 48 || c == 49 || e[11])
                    check("stop", stop_s, 1'b1);
                if (e === expect_lv(0))
                    check("no stop", stop_s, 1'b0);
            end
        end
        check("idle", lv, expect_lv(0));
        check("comm", nc, c == 37 && src == `SRC_TERMINAL);
        check("clear", nr, c == 50 && rte && rtc);
    endtask

    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // ----------------
    // Tests
    // ----------------
    // Watchdog well beyond the expected run of about 3500 cycles
    initial begin
        #100000;
        fails++;
        $display("watchdog expired");
        conclude();
    end

    initial begin
        fails = 0;
        n_compared = 0;
        nrst_i = 1'b0;
        func_code_i = '0;
        {src, dir, sel, mode, rte, rtc} = '0;
        repeat (8) @(posedge clk_i);
        #1 check("reset", lv, 20'h00000);
        nrst_i = 1'b1;
        // Every code under three setting sets
        for (int s = 0; s < 3; s++) begin
            @(posedge clk_i);
            #1 src = t_src[s];
            sel = t_sel[s];
            {dir, mode, rte, rtc} = {T_DIR[s], T_MODE[s], T_RTE[s], T_RTC[s]};
            for (int c = 0; c < 64; c++)
                run_code(c);
            $display("test code sweep %0d done", s);
        end
        // Direction setting reaches the output one edge later
        @(posedge clk_i);
        #1 dir = ~dir;
        @(posedge clk_i);
        #1 check("dir", lv, expect_lv(0));
        $display("test setting latency done");
        // Two terminals closed together, then a reset in mid-run
        func_code_i = '0;
        func_code_i[0 +: `CODE_W] = `FN_HOLD_FREQ;
        func_code_i[(N-1)*`CODE_W +: `CODE_W] = `FN_FREQ_LOCK;
        contacts.set_level(0, 1'b1);
        contacts.set_level(N - 1, 1'b1);
        repeat (8) @(posedge clk_i);
        #1 check("or", lv, expect_lv(21) | expect_lv(34));
        nrst_i = 1'b0;
        #1 check("mid reset", {lv, stop_s}, 21'h0);
        repeat (8) @(posedge clk_i);
        #1 nrst_i = 1'b1;
        repeat (8) @(posedge clk_i);
        #1 check("after reset", lv, expect_lv(21) | expect_lv(34));
        $display("test multi terminal and reset done");
        conclude();
    end
endmodule

bind di_terminal_function_decoder di_decoder_checker #(.N(N)) chk (
    .clk_i(clk_i), .nrst_i(nrst_i), .term_i(term_i),
    .func_code_i(func_code_i), .cmd_source_i(cmd_source_i),
    .pid_direction_setting_i(pid_direction_setting_i),
    .pid_bank_switch_selector_i(pid_bank_switch_selector_i),
    .running_time_enable_setting_i(running_time_enable_setting_i),
    .running_time_counter_setting_i(running_time_counter_setting_i),
    .hold_freq_o(hold_freq_o), .dc_brake_o(dc_brake_o),
    .external_fault_report_o(external_fault_report_o), .stop_o(stop_o),
    .pid_dir_o(pid_dir_o), .panel_stop_o(panel_stop_o),
    .switch_to_comm_o(switch_to_comm_o), .pid_bank_two_o(pid_bank_two_o),
    .emerg_stop_o(emerg_stop_o), .clr_runtime_o(clr_runtime_o),
    .speed_mode_force_o(speed_mode_force_o), .torque_mode_o(torque_mode_o)
);
